// File: verilog/isf_top.sv
`timescale 1ns/1ps
`include "isf_map.svh"
module isf_top
  import isf_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        serial_clock_line_in,
  input  wire logic        serial_data_line_in,
  output logic             serial_data_line_out,
  output logic             serial_data_line_oe,
  input  wire logic        master_mode,
  input  wire logic        start_generated,
  input  wire logic        arbitration_lost_flag,
  input  wire logic        shift_out_latch
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic                   scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
  logic                   unit_enable_bit_r, en_d_r, ald_d_r, exit_cmd_r, wrel_cmd_r;
  logic [`ISF_EVT_W-1:0]  evt_r, evt_nxt, mask_r;
  logic [3:0]             bit_cnt_r, status_flags;
  isf_bus_type            bus_r, bus_nxt;
  logic                   transmit_direction_flag_r, trc_nxt, ack_detected_flag_r;
  logic                   start_detected_flag_r, stop_detected_flag_r, spd_armed_r;
  logic                   en_fall, ald_rise, dir_evt, ninth_rise, byte_first_rise;
  logic                   trc_clr_all, trc_set, trc_clr_role, ack_clr, std_clr, spd_clr;
  logic                   acc_done, wr_done, unmapped;
  logic [31:0]            rd_mux;

  // ----------------------------------------
  // link inputs
  // ----------------------------------------
  isf_sync #(.WIDTH(2)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .din     ({serial_clock_line_in, serial_data_line_in}),
    .dout    ({scl_s, sda_s})
  );

  isf_cond_det u_det (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .scl_s     (scl_s),
    .sda_s     (sda_s),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  // no wait state: answer registered at the setup edge
  assign acc_done = psel && penable && pready;
  assign wr_done  = acc_done && pwrite && ce;
  assign unmapped = (paddr != `ISF_OFF_STATUS) && (paddr != `ISF_OFF_CTRL) &&
                    (paddr != `ISF_OFF_EVT) && (paddr != `ISF_OFF_MASK);
  assign status_flags = {transmit_direction_flag_r, ack_detected_flag_r,
                         start_detected_flag_r, stop_detected_flag_r};

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      `ISF_OFF_STATUS: rd_mux[3:0] = status_flags;
      `ISF_OFF_CTRL:   rd_mux[`ISF_CT_EN] = unit_enable_bit_r;
      `ISF_OFF_EVT:    rd_mux[`ISF_EVT_W-1:0] = evt_r;
      `ISF_OFF_MASK:   rd_mux[`ISF_EVT_W-1:0] = mask_r;
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (psel && !penable) begin
        pready  <= 1'b1;
        prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr <= unmapped;
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // control register and command pulses
  // ----------------------------------------
  // commands self-clear so a second write is a second command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_enable_bit_r <= `ISF_CTRL_RST;
      exit_cmd_r        <= 1'b0;
      wrel_cmd_r        <= 1'b0;
      mask_r            <= `ISF_MASK_RST;
      en_d_r            <= 1'b0;
      ald_d_r           <= 1'b0;
    end else if (ce) begin
      en_d_r     <= unit_enable_bit_r;
      ald_d_r    <= arbitration_lost_flag;
      exit_cmd_r <= 1'b0;
      wrel_cmd_r <= 1'b0;
      if (wr_done && paddr == `ISF_OFF_CTRL) begin
        unit_enable_bit_r <= pwdata[`ISF_CT_EN];
        exit_cmd_r        <= pwdata[`ISF_CT_EXIT];
        wrel_cmd_r        <= pwdata[`ISF_CT_WREL];
      end
      if (wr_done && paddr == `ISF_OFF_MASK) begin
        mask_r <= pwdata[`ISF_EVT_W-1:0];
      end
    end
  end

  assign en_fall  = ce && en_d_r && !unit_enable_bit_r;
  assign ald_rise = ce && arbitration_lost_flag && !ald_d_r;

  // ----------------------------------------
  // byte tracking
  // ----------------------------------------
  assign ninth_rise      = scl_rise && bit_cnt_r == `ISF_CNT_ACK;
  assign byte_first_rise = scl_rise &&
                           (bit_cnt_r == `ISF_CNT_ZERO || bit_cnt_r == `ISF_CNT_LAST);
  // direction bit is the line level at the eighth clock of the address byte
  assign dir_evt         = scl_rise && bit_cnt_r == `ISF_CNT_DIR && bus_r == ISF_ADDR;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_r <= `ISF_CNT_ZERO;
    end else if (ce) begin
      if (start_det || stop_det || !unit_enable_bit_r) begin
        bit_cnt_r <= `ISF_CNT_ZERO;
      end else if (scl_rise) begin
        bit_cnt_r <= (bit_cnt_r == `ISF_CNT_LAST) ? `ISF_CNT_ONE : bit_cnt_r + `ISF_CNT_ONE;
      end
    end
  end

  always_comb begin
    bus_nxt = bus_r;
    unique case (bus_r)
      ISF_IDLE, ISF_DATA: begin
        if (start_det) begin
          bus_nxt = ISF_ADDR;
        end
      end
      ISF_ADDR: begin
        if (scl_fall && bit_cnt_r == `ISF_CNT_LAST) begin
          bus_nxt = ISF_DATA;
        end
      end
    endcase
    if (stop_det || !unit_enable_bit_r || exit_cmd_r) begin
      bus_nxt = ISF_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_r <= ISF_IDLE;
    end else if (ce) begin
      bus_r <= bus_nxt;
    end
  end

  // ----------------------------------------
  // transmit direction flag
  // ----------------------------------------
  // common clears
  assign trc_clr_all  = stop_det || exit_cmd_r || en_fall || wrel_cmd_r || ald_rise;
  assign trc_set      = (master_mode && start_generated) ||
                        (dir_evt && (master_mode ? !sda_s : sda_s));
  assign trc_clr_role = (dir_evt && (master_mode ? sda_s : !sda_s)) ||
                        (!master_mode && start_det);

  always_comb begin
    trc_nxt = transmit_direction_flag_r;
    if (trc_clr_all) begin
      trc_nxt = 1'b0;
    end else if (trc_set) begin
      trc_nxt = 1'b1;
    end else if (trc_clr_role) begin
      trc_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_direction_flag_r <= 1'b0;
    end else if (ce) begin
      transmit_direction_flag_r <= trc_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_data_line_out <= 1'b1;
      serial_data_line_oe  <= 1'b0;
    end else if (ce) begin
      serial_data_line_out <= shift_out_latch;
      serial_data_line_oe  <= trc_nxt && (master_mode || bus_nxt == ISF_DATA);
    end
  end

  // ----------------------------------------
  // ack, start and stop flags
  // ----------------------------------------
  // ack clear events
  assign ack_clr = stop_det || byte_first_rise || exit_cmd_r || en_fall;
  assign std_clr = stop_det || (byte_first_rise && bus_r == ISF_DATA) ||
                   exit_cmd_r || en_fall;
  // stop flag leaves after a new start and its first clock, or when the enable falls
  assign spd_clr = (byte_first_rise && spd_armed_r && bus_r == ISF_ADDR) || en_fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_detected_flag_r <= 1'b0;
    end else if (ce) begin
      if (ninth_rise && !sda_s && unit_enable_bit_r) begin
        ack_detected_flag_r <= 1'b1;
      end else if (ack_clr) begin
        ack_detected_flag_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_detected_flag_r <= 1'b0;
    end else if (ce) begin
      if (start_det && unit_enable_bit_r) begin
        start_detected_flag_r <= 1'b1;
      end else if (std_clr) begin
        start_detected_flag_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_detected_flag_r <= 1'b0;
      spd_armed_r          <= 1'b0;
    end else if (ce) begin
      if (stop_det && unit_enable_bit_r) begin
        stop_detected_flag_r <= 1'b1;
        spd_armed_r          <= 1'b0;
      end else if (spd_clr) begin
        stop_detected_flag_r <= 1'b0;
        spd_armed_r          <= 1'b0;
      end else if (start_det && stop_detected_flag_r) begin
        spd_armed_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // interrupt events
  // ----------------------------------------
  // a new event in the clearing cycle survives the clear
  always_comb begin
    evt_nxt = evt_r;
    if (wr_done && paddr == `ISF_OFF_EVT) begin
      evt_nxt = evt_r & ~pwdata[`ISF_EVT_W-1:0];
    end
    if (unit_enable_bit_r) begin
      evt_nxt[`ISF_EV_START] = evt_nxt[`ISF_EV_START] | start_det;
      evt_nxt[`ISF_EV_STOP]  = evt_nxt[`ISF_EV_STOP] | stop_det;
      evt_nxt[`ISF_EV_ACK]   = evt_nxt[`ISF_EV_ACK] | (ninth_rise && !sda_s);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_r <= `ISF_MASK_RST;
      irq   <= 1'b0;
    end else if (ce) begin
      evt_r <= evt_nxt;
      irq   <= |(evt_nxt & mask_r);
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rx_hiz;
    !transmit_direction_flag_r |-> !serial_data_line_oe;
  endproperty
  a_rx_hiz: assert property (p_rx_hiz) else $error("line driven in receive");
  property p_tx_drive;
    (ce && trc_nxt && master_mode) |=>
      serial_data_line_oe && serial_data_line_out == $past(shift_out_latch);
  endproperty
  a_tx_drive: assert property (p_tx_drive) else $error("latch not driven");
  property p_trc_clear;
    (ce && (stop_det || exit_cmd_r || en_fall || ald_rise)) |=> !transmit_direction_flag_r;
  endproperty
  a_trc_clear: assert property (p_trc_clear) else $error("direction not cleared");
  property p_master_start;
    (ce && master_mode && start_generated && !trc_clr_all) |=> transmit_direction_flag_r;
  endproperty
  a_master_start: assert property (p_master_start) else $error("no set on start");
  property p_slave_dir;
    (ce && !master_mode && dir_evt && !trc_clr_all) |=> transmit_direction_flag_r == $past(sda_s);
  endproperty
  a_slave_dir: assert property (p_slave_dir) else $error("slave direction wrong");
  property p_wrel;
    (ce && wrel_cmd_r) |=> !transmit_direction_flag_r && !serial_data_line_oe;
  endproperty
  a_wrel: assert property (p_wrel) else $error("wait release kept drive");
  property p_ack_set;
    (ce && ninth_rise && !sda_s && unit_enable_bit_r) |=> ack_detected_flag_r;
  endproperty
  a_ack_set: assert property (p_ack_set) else $error("ack not flagged");
  property p_ack_clr;
    (ce && ack_clr && !(ninth_rise && !sda_s)) |=> !ack_detected_flag_r;
  endproperty
  a_ack_clr: assert property (p_ack_clr) else $error("ack not cleared");
  property p_std;
    (ce && start_det && unit_enable_bit_r) |=> start_detected_flag_r && bus_r == ISF_ADDR;
  endproperty
  a_std: assert property (p_std) else $error("start flag missing");
  property p_spd_hold;
    (ce && stop_detected_flag_r && !spd_clr) |=> stop_detected_flag_r;
  endproperty
  a_spd_hold: assert property (p_spd_hold) else $error("stop flag dropped");
  property p_spd_set;
    (ce && stop_det && unit_enable_bit_r) |=> stop_detected_flag_r ##1 stop_detected_flag_r;
  endproperty
  a_spd_set: assert property (p_spd_set) else $error("stop flag missing");
  property p_ro;
    (ce && wr_done && paddr == `ISF_OFF_STATUS && !scl_rise && !start_det && !stop_det &&
     !exit_cmd_r && !wrel_cmd_r && !en_fall && !ald_rise && !start_generated)
      |=> status_flags == $past(status_flags);
  endproperty
  a_ro: assert property (p_ro) else $error("write changed status");
  c_ack:   cover property (ce && ninth_rise && !sda_s);
  c_stop:  cover property (stop_detected_flag_r ##1 !stop_detected_flag_r);
  c_drive: cover property (serial_data_line_oe && !master_mode);
endmodule

// File: verilog/isf_map.svh
`ifndef ISF_MAP_SVH
`define ISF_MAP_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define ISF_OFF_STATUS 8'h00
`define ISF_OFF_CTRL   8'h04
`define ISF_OFF_EVT    8'h08
`define ISF_OFF_MASK   8'h0C

// ----------------------------------------
// field positions
// ----------------------------------------
`define ISF_ST_SPD   0
`define ISF_ST_STD   1
`define ISF_ST_ACKD  2
`define ISF_ST_TRC   3
`define ISF_CT_EN    0
`define ISF_CT_EXIT  1
`define ISF_CT_WREL  2
`define ISF_EV_START 0
`define ISF_EV_STOP  1
`define ISF_EV_ACK   2

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define ISF_EVT_W    3
`define ISF_CTRL_RST 1'b0
`define ISF_MASK_RST 3'h0
`define ISF_CNT_DIR  4'h7
`define ISF_CNT_ACK  4'h8
`define ISF_CNT_LAST 4'h9
`define ISF_CNT_ZERO 4'h0
`define ISF_CNT_ONE  4'h1

`endif

// File: verilog/isf_pkg.sv
package isf_pkg;
  typedef enum logic [1:0] {ISF_IDLE, ISF_ADDR, ISF_DATA} isf_bus_type;
endpackage

// File: verilog/isf_sync.sv
`timescale 1ns/1ps
module isf_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_r;

  // second stage is the only reader of the first
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        meta_r[i] <= 1'b1;
        dout[i]   <= 1'b1;
      end else if (ce) begin
        meta_r[i] <= din[i];
        dout[i]   <= meta_r[i];
      end
    end
  end
endmodule

// File: verilog/isf_cond_det.sv
`timescale 1ns/1ps
module isf_cond_det (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic scl_s,
  input  wire logic sda_s,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_det,
  output logic      stop_det
);
  logic scl_d_r;
  logic sda_d_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else if (ce) begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // data moving while clock stays high marks a bus condition
  always_comb begin
    scl_rise  = ce && scl_s && !scl_d_r;
    scl_fall  = ce && !scl_s && scl_d_r;
    start_det = ce && scl_s && scl_d_r && sda_d_r && !sda_s;
    stop_det  = ce && scl_s && scl_d_r && !sda_d_r && sda_s;
  end
endmodule

// File: tb/isf_far_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// far-side bus device, open-drain drivers
// ----------------------------------------
module isf_far_model (
  output logic scl_low,
  output logic sda_low
);
  // both lines released at time zero, pull-ups hold them high
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // data changes only while the clock is low, 80 ns bit period
  task automatic bit_out(input logic b);
    sda_low = ~b;
    #20 scl_low = 1'b0;
    #40 scl_low = 1'b1;
    #20;
  endtask

  task automatic byte_out(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      bit_out(d[i]);
    end
  endtask

  // works from idle and as a repeated start after a bit
  task automatic start_cond();
    #7 sda_low = 1'b0;
    #20 scl_low = 1'b0;
    #40 sda_low = 1'b1;
    #40 scl_low = 1'b1;
    #20;
  endtask

  // clock left released afterwards: it stands high between frames
  task automatic stop_cond();
    sda_low = 1'b1;
    #20 scl_low = 1'b0;
    #40 sda_low = 1'b0;
    #40;
  endtask
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
`include "isf_map.svh"
module tb;
  logic        pclk;
  logic        presetn;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        sda_out;
  logic        sda_oe;
  logic        master_mode;
  logic        start_gen;
  logic        arb_lost;
  logic        latch;
  logic        scl_low;
  logic        sda_low;
  int          bad_count = 0;
  int          comparisons = 0;
  // open-drain wires with pull-ups
  wire         scl_line = ~scl_low;
  wire         sda_line = ~(sda_low | (sda_oe & ~sda_out));

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  isf_top uut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq),
    .serial_clock_line_in(scl_line), .serial_data_line_in(sda_line),
    .serial_data_line_out(sda_out), .serial_data_line_oe(sda_oe),
    .master_mode(master_mode), .start_generated(start_gen),
    .arbitration_lost_flag(arb_lost), .shift_out_latch(latch)
  );

  isf_far_model far (
    .scl_low(scl_low),
    .sda_low(sda_low)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic close_out();
    if (bad_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] x);
    comparisons++;
    if (seen !== x) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, x, seen);
    end
  endtask

  task automatic chk1(input string nm, input logic seen, input logic x);
    chk(nm, {31'h0, seen}, {31'h0, x});
  endtask

  // request held until pready is sampled high; the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdm(input string nm, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, r & m, x);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x);
    rdm(nm, a, 32'hFFFFFFFF, x);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  // pin edges need a few clocks through the synchronisers
  task automatic settle();
    repeat (6) @(posedge pclk);
  endtask

  task automatic gen_start();
    @(posedge pclk);
    start_gen <= 1'b1;
    @(posedge pclk);
    start_gen <= 1'b0;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    rd("status reset", `ISF_OFF_STATUS, 32'h0);
    rd("ctrl reset", `ISF_OFF_CTRL, 32'h0);
    rd("evt reset", `ISF_OFF_EVT, 32'h0);
    rd("mask reset", `ISF_OFF_MASK, 32'h0);
    chk1("oe reset", sda_oe, 1'b0);
    apb(1'b0, 8'h10, 32'h0, r, e);
    chk1("unmapped err", e, 1'b1);
    chk("unmapped data", r, 32'h0);
    wr(`ISF_OFF_CTRL, 32'h1);
    rd("ctrl enable", `ISF_OFF_CTRL, 32'h1);
  endtask

  task automatic t_slave_read();
    far.start_cond();
    settle();
    rd("start flag", `ISF_OFF_STATUS, 32'h2);
    far.byte_out(8'hA1);
    settle();
    chk1("oe before ninth fall", sda_oe, 1'b0);
    rd("slave dir set", `ISF_OFF_STATUS, 32'hA);
    latch <= 1'b0;
    far.bit_out(1'b0);
    settle();
    chk1("oe after ninth fall", sda_oe, 1'b1);
    chk1("out follows latch", sda_out, 1'b0);
    rd("ack flag", `ISF_OFF_STATUS, 32'hE);
    wr(`ISF_OFF_STATUS, 32'h0);
    rd("status write ignored", `ISF_OFF_STATUS, 32'hE);
    latch <= 1'b1;
    far.bit_out(1'b1);
    settle();
    rd("first clock clears", `ISF_OFF_STATUS, 32'h8);
    wr(`ISF_OFF_CTRL, 32'h5);
    settle();
    rd("wait release", `ISF_OFF_STATUS, 32'h0);
    chk1("oe after release", sda_oe, 1'b0);
    far.stop_cond();
    settle();
    rd("stop flag", `ISF_OFF_STATUS, 32'h1);
    far.start_cond();
    settle();
    rd("stop held", `ISF_OFF_STATUS, 32'h3);
    far.bit_out(1'b1);
    settle();
    rd("stop cleared", `ISF_OFF_STATUS, 32'h2);
    wr(`ISF_OFF_CTRL, 32'h0);
    rd("enable fall", `ISF_OFF_STATUS, 32'h0);
    far.stop_cond();
    settle();
    rd("stop while off", `ISF_OFF_STATUS, 32'h0);
    wr(`ISF_OFF_CTRL, 32'h1);
  endtask

  task automatic t_irq();
    wr(`ISF_OFF_MASK, 32'h1);
    wr(`ISF_OFF_EVT, 32'h7);
    settle();
    chk1("irq idle", irq, 1'b0);
    far.start_cond();
    settle();
    chk1("irq start", irq, 1'b1);
    wr(`ISF_OFF_EVT, 32'h1);
    settle();
    chk1("irq cleared", irq, 1'b0);
    far.byte_out(8'hA1);
    far.bit_out(1'b0);
    settle();
    rd("ack event", `ISF_OFF_EVT, 32'h4);
    far.start_cond();
    settle();
    rdm("restart dir", `ISF_OFF_STATUS, 32'h8, 32'h0);
    far.byte_out(8'hA0);
    far.bit_out(1'b1);
    settle();
    rd("write address", `ISF_OFF_STATUS, 32'h2);
    far.stop_cond();
    settle();
    rd("all events", `ISF_OFF_EVT, 32'h7);
    wr(`ISF_OFF_MASK, 32'h0);
    settle();
    chk1("irq masked", irq, 1'b0);
    wr(`ISF_OFF_EVT, 32'h7);
    rd("events cleared", `ISF_OFF_EVT, 32'h0);
  endtask

  task automatic t_master();
    master_mode <= 1'b1;
    gen_start();
    far.start_cond();
    settle();
    rdm("master start dir", `ISF_OFF_STATUS, 32'h8, 32'h8);
    chk1("master oe", sda_oe, 1'b1);
    @(posedge pclk);
    arb_lost <= 1'b1;
    settle();
    rdm("arb lost dir", `ISF_OFF_STATUS, 32'h8, 32'h0);
    chk1("arb lost oe", sda_oe, 1'b0);
    arb_lost <= 1'b0;
    far.byte_out(8'hA0);
    far.bit_out(1'b0);
    settle();
    rd("dir bit zero", `ISF_OFF_STATUS, 32'hE);
    wr(`ISF_OFF_CTRL, 32'h3);
    settle();
    rd("exit command", `ISF_OFF_STATUS, 32'h0);
    gen_start();
    far.start_cond();
    far.byte_out(8'hA1);
    far.bit_out(1'b0);
    settle();
    rdm("dir bit one", `ISF_OFF_STATUS, 32'h8, 32'h0);
    far.stop_cond();
    settle();
    wr(`ISF_OFF_CTRL, 32'h0);
    rd("enable fall stop", `ISF_OFF_STATUS, 32'h0);
  endtask

  // a start made while the clock enable is low is never seen
  task automatic t_freeze();
    wr(`ISF_OFF_CTRL, 32'h1);
    wr(`ISF_OFF_EVT, 32'h7);
    @(posedge pclk);
    ce <= 1'b0;
    far.start_cond();
    @(posedge pclk);
    ce <= 1'b1;
    rd("frozen status", `ISF_OFF_STATUS, 32'h0);
    rd("frozen events", `ISF_OFF_EVT, 32'h0);
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    presetn     = 1'b0;
    ce          = 1'b1;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0000_0000;
    master_mode = 1'b0;
    start_gen   = 1'b0;
    arb_lost    = 1'b0;
    latch       = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_slave_read();
    t_irq();
    t_master();
    t_freeze();
    close_out();
  end

  // whole run needs some 8 us
  initial begin
    #200000;
    bad_count++;
    close_out();
  end
endmodule
